// ==== common/pwm_ctrl_pkg.sv ====
// constants, register map and mode encodings of the pwm output control
// assumes one 100 MHz peripheral clock and an AHB-Lite register port
package pwm_ctrl_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFS_FUNC_CTRL  = 8'h00;
    localparam logic [7:0] OFS_CUT_CH0    = 8'h04;
    localparam logic [7:0] OFS_CUT_CH1    = 8'h08;
    localparam logic [7:0] OFS_MODE_REG   = 8'h0C;
    localparam logic [7:0] OFS_RUN_REG    = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;
    localparam logic [7:0] OFS_CH0_CMP_B  = 8'h18;
    localparam logic [7:0] OFS_CH0_BUF_D  = 8'h1C;

    // pwm_function_control fields
    localparam int POS_COMBO_LO       = 0;
    localparam int POS_COMBO_HI       = 1;
    localparam int POS_NORMAL_LEVEL   = 2;
    localparam int POS_COUNTER_LEVEL  = 3;
    localparam int POS_EXT_CLK_SEL    = 6;
    localparam int POS_THREE_OUT_PWM  = 7;
    localparam logic [7:0] FUNC_CTRL_WMASK = 8'hCF;

    // timer_mode_reg fields
    localparam int POS_LOCKSTEP       = 0;
    localparam int POS_CH0_B_BUF_EN   = 5;
    localparam logic [7:0] MODE_REG_WMASK = 8'hF1;

    // run register fields
    localparam int POS_CH0_RUN        = 0;
    localparam int POS_CH1_RUN        = 1;

    // cutoff field positions inside a select register, per pin a..d
    localparam int POS_CUT_A          = 6;
    localparam int POS_CUT_B          = 4;
    localparam int POS_CUT_C          = 2;
    localparam int POS_CUT_D          = 0;

    // reset values
    localparam logic [7:0]  RST_FUNC_CTRL = 8'h00;
    localparam logic [7:0]  RST_CUT_SEL   = 8'h00;
    localparam logic [7:0]  RST_MODE_REG  = 8'h00;
    localparam logic [1:0]  RST_RUN       = 2'b00;
    localparam logic [15:0] RST_COMPARE   = 16'hFFFF;

    // pin index order: ch0 a,b,c,d then ch1 a,b,c,d
    localparam int NUM_PINS = 8;
    localparam logic [7:0] NORMAL_PHASE_PINS  = 8'h32;
    localparam logic [7:0] COUNTER_PHASE_PINS = 8'hC8;

    typedef enum logic [1:0] {
        COMBO_TIMER      = 2'b00,
        COMBO_RESET_SYNC = 2'b01,
        COMBO_COMP_UNDER = 2'b10,
        COMBO_COMP_MATCH = 2'b11
    } combo_mode_e;

    typedef enum logic [1:0] {
        CUT_OFF   = 2'b00,
        CUT_HIZ   = 2'b01,
        CUT_LOW   = 2'b10,
        CUT_HIGH  = 2'b11
    } cut_state_e;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b10
    } bus_state_e;

endpackage : pwm_ctrl_pkg

// ==== hw/pin_output_stage.sv ====
// one pwm pin: level polarity and forced cutoff override, registered
// assumes phase activity and cutoff event are synchronous to mclk
`timescale 1ns/1ns
module pin_output_stage
    import pwm_ctrl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       pwmMode,
    input  wire logic       levelSel,
    input  wire logic       phaseActive,
    input  wire logic [1:0] cutSel,
    input  wire logic       cutEvent,
    output logic            pinOut,
    output logic            pinOeN
);

    logic levelOut;

    always_comb begin
        if (pwmMode) begin
            levelOut = levelSel ? phaseActive : ~phaseActive;
        end else begin
            levelOut = phaseActive;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pinOut <= 1'b0;
            pinOeN <= 1'b1;
        end else if (cutEvent) begin
            case (cut_state_e'(cutSel))
                CUT_HIZ: begin
                    pinOut <= 1'b0;
                    pinOeN <= 1'b1;
                end
                CUT_LOW: begin
                    pinOut <= 1'b0;
                    pinOeN <= 1'b0;
                end
                CUT_HIGH: begin
                    pinOut <= 1'b1;
                    pinOeN <= 1'b0;
                end
                default: begin
                    pinOut <= levelOut;
                    pinOeN <= 1'b0;
                end
            endcase
        end else begin
            pinOut <= levelOut;
            pinOeN <= 1'b0;
        end
    end

endmodule : pin_output_stage

// ==== hw/complementary_pwm_output_control.sv ====
// output control of a two-channel pwm timer: modes, levels, cutoff
// assumes AHB-Lite single word transfers, counters live outside
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns

module complementary_pwm_output_control
    import pwm_ctrl_pkg::*;
#(
    parameter int CMP_WIDTH = 16
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic [NUM_PINS-1:0]  phaseActive,
    input  wire logic                 ch1Underflow,
    input  wire logic                 ch0MatchA,
    input  wire logic                 cutoffEvent,
    output logic [NUM_PINS-1:0]       pinOut,
    output logic [NUM_PINS-1:0]       pinOeN,
    output logic                      ch0Run,
    output logic                      ch1Run,
    output logic                      lockstep,
    output logic                      pwmModeActive,
    output logic                      transferPulse,
    output logic [CMP_WIDTH-1:0]      ch0CompareB
);

    // true in the two pwm families where the level bits apply
    function automatic logic isPwmMode(input logic [7:0] fc);
        logic [1:0] m;
        m = fc[POS_COMBO_HI:POS_COMBO_LO];
        return (m != COMBO_TIMER) && !fc[POS_THREE_OUT_PWM];
    endfunction : isPwmMode

    // two-bit cutoff field of pin p (0..3 = a..d) of a select register
    function automatic logic [1:0] cutField(input logic [7:0] sel,
                                            input int p);
        logic [1:0] f;
        case (p)
            0:       f = sel[POS_CUT_A +: 2];
            1:       f = sel[POS_CUT_B +: 2];
            2:       f = sel[POS_CUT_C +: 2];
            default: f = sel[POS_CUT_D +: 2];
        endcase
        return f;
    endfunction : cutField

    // write strobe of one register, valid in its data phase
    function automatic logic wrHit(input bus_state_e st,
                                   input logic [7:0] a,
                                   input logic [7:0] ofs);
        return (st == BUS_WRITE) && (a == ofs);
    endfunction : wrHit

    bus_state_e           busState_ff;
    bus_state_e           nxt_busState;
    logic [7:0]           addr_ff;
    logic                 addrHit;
    logic [7:0]           funcCtrl_ff;
    logic [7:0]           cutCh0_ff;
    logic [7:0]           cutCh1_ff;
    logic [7:0]           modeReg_ff;
    logic [1:0]           run_ff;
    logic [CMP_WIDTH-1:0] bufD_ff;
    logic [CMP_WIDTH-1:0] cmpB_ff;
    logic                 transfer_ff;
    logic                 transferPoint;
    logic                 accept;
    logic                 wrRun;
    logic                 wrCut;
    logic                 wrFunc;
    logic                 wrMode;
    logic                 wrBufD;
    logic                 wrCmpB;
    logic [1:0]           nxt_run;
    logic                 pwmMode;
    logic [31:0]          readValue;
    logic [7:0]           wByte;

    assign accept  = hsel && htrans[1] && hready;
    assign addrHit = (haddr[1:0] == 2'b00);
    assign wByte   = hwdata[7:0];
    assign pwmMode = isPwmMode(funcCtrl_ff);
    // one strobe per register, except wrCut, which both cutoff registers share and which each qualifies by its own address
    assign wrRun   = wrHit(busState_ff, addr_ff, OFS_RUN_REG);
    assign wrFunc  = wrHit(busState_ff, addr_ff, OFS_FUNC_CTRL);
    assign wrMode  = wrHit(busState_ff, addr_ff, OFS_MODE_REG);
    assign wrBufD  = wrHit(busState_ff, addr_ff, OFS_CH0_BUF_D);
    assign wrCmpB  = wrHit(busState_ff, addr_ff, OFS_CH0_CMP_B);
    // cutoff fields are only safe to change with both counters stopped
    assign wrCut   = (busState_ff == BUS_WRITE) && (run_ff == 2'b00);

    // bus phase tracking; a read adds one wait state so hrdata is a flop
    always_comb begin
        case (busState_ff)
            BUS_IDLE, BUS_WRITE: begin
                if (accept && addrHit) begin
                    nxt_busState = hwrite ? BUS_WRITE : BUS_READ;
                end else if (accept) begin
                    nxt_busState = hwrite ? BUS_IDLE : BUS_READ;
                end else begin
                    nxt_busState = BUS_IDLE;
                end
            end
            BUS_READ: nxt_busState = BUS_IDLE;
            default:  nxt_busState = BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busState_ff <= BUS_IDLE;
            addr_ff     <= 8'h00;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            busState_ff <= nxt_busState;
            if (accept) begin
                addr_ff <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
            end
            hreadyout   <= !(accept && !hwrite);
            hresp       <= 1'b0;
        end
    end

    always_comb begin
        case (addr_ff)
            OFS_FUNC_CTRL: readValue = {24'h000000, funcCtrl_ff};
            OFS_CUT_CH0:   readValue = {24'h000000, cutCh0_ff};
            OFS_CUT_CH1:   readValue = {24'h000000, cutCh1_ff};
            OFS_MODE_REG:  readValue = {24'h000000, modeReg_ff};
            OFS_RUN_REG:   readValue = {30'h00000000, run_ff};
            OFS_STATUS:    readValue = {14'h0000, pinOut, pinOeN,
                                        cutoffEvent, transfer_ff};
            OFS_CH0_CMP_B: readValue = 32'(cmpB_ff);
            OFS_CH0_BUF_D: readValue = 32'(bufD_ff);
            default:       readValue = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
        end else if (busState_ff == BUS_READ) begin
            hrdata <= readValue;
        end
    end

    // mode and level configuration
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            funcCtrl_ff <= RST_FUNC_CTRL;
        end else if (wrFunc) begin
            // all four encodings decode; software avoids the rest
            funcCtrl_ff <= wByte & FUNC_CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            modeReg_ff <= RST_MODE_REG;
        end else if (wrMode) begin
            modeReg_ff <= wByte & MODE_REG_WMASK;
        end
    end

    // cutoff select registers, same layout for both channels
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cutCh0_ff <= RST_CUT_SEL;
        end else if (wrCut && addr_ff == OFS_CUT_CH0) begin
            cutCh0_ff <= wByte;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cutCh1_ff <= RST_CUT_SEL;
        end else if (wrCut && addr_ff == OFS_CUT_CH1) begin
            cutCh1_ff <= wByte;
        end
    end

    // run flags; in lockstep channel 1 follows channel 0
    always_comb begin
        nxt_run = run_ff;
        if (wrRun) begin
            nxt_run = wByte[POS_CH1_RUN:POS_CH0_RUN];
            if (modeReg_ff[POS_LOCKSTEP]) begin
                nxt_run = {2{wByte[POS_CH0_RUN]}};
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run_ff <= RST_RUN;
        end else begin
            run_ff <= nxt_run;
        end
    end

    // buffer transfer point picked by the complementary encoding
    always_comb begin
        case (combo_mode_e'(funcCtrl_ff[POS_COMBO_HI:POS_COMBO_LO]))
            COMBO_COMP_UNDER: transferPoint = ch1Underflow;
            COMBO_COMP_MATCH: transferPoint = ch0MatchA;
            default:          transferPoint = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            transfer_ff <= 1'b0;
        end else begin
            transfer_ff <= transferPoint && run_ff[0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bufD_ff <= RST_COMPARE;
        end else if (wrBufD) begin
            bufD_ff <= hwdata[CMP_WIDTH-1:0];
        end
    end

    // a buffer transfer wins over a direct write in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmpB_ff <= RST_COMPARE;
        end else if (modeReg_ff[POS_CH0_B_BUF_EN] && transferPoint
                     && run_ff[0]) begin
            cmpB_ff <= bufD_ff;
        end else if (wrCmpB) begin
            cmpB_ff <= hwdata[CMP_WIDTH-1:0];
        end
    end

    // per-pin output stages; pins not in either phase use normal level
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic levelSel;
        logic [1:0] cutSel;
        assign levelSel = COUNTER_PHASE_PINS[i]
                        ? funcCtrl_ff[POS_COUNTER_LEVEL]
                        : funcCtrl_ff[POS_NORMAL_LEVEL];
        assign cutSel = (i < 4) ? cutField(cutCh0_ff, i)
                                : cutField(cutCh1_ff, i - 4);
        pin_output_stage u_stage (
            .mclk        (mclk),
            .nrst        (nrst),
            .pwmMode     (pwmMode),
            .levelSel    (levelSel),
            .phaseActive (phaseActive[i]),
            .cutSel      (cutSel),
            .cutEvent    (cutoffEvent),
            .pinOut      (pinOut[i]),
            .pinOeN      (pinOeN[i])
        );
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ch0Run        <= 1'b0;
            ch1Run        <= 1'b0;
            lockstep      <= 1'b0;
            pwmModeActive <= 1'b0;
        end else begin
            ch0Run        <= nxt_run[0];
            ch1Run        <= nxt_run[1];
            lockstep      <= modeReg_ff[POS_LOCKSTEP];
            pwmModeActive <= pwmMode;
        end
    end

    assign transferPulse = transfer_ff;
    assign ch0CompareB   = cmpB_ff;

endmodule : complementary_pwm_output_control

// ==== verification/power_stage_model.sv ====
// power stage behind the eight pwm pins: gate level per switch
// assumes pinOeN low means driven; a released gate is pulled down
`timescale 1ns/1ns
module power_stage_model (
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOeN,
    output logic      [7:0] gate
);
    // pull-down keeps a released switch off, never left floating
    assign gate = pinOut & ~pinOeN;
endmodule : power_stage_model

// ==== verification/complementary_pwm_output_control_props.sv ====
// port assertions of the pwm output control
// assumes one clock domain, bound onto the design top
`timescale 1ns/1ns
module pwm_ctrl_checker
    import pwm_ctrl_pkg::*;
#(
    parameter int CMP_WIDTH = 16
) (
    input wire logic                 mclk,
    input wire logic                 nrst,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hsel,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic [NUM_PINS-1:0]  phaseActive,
    input wire logic                 ch1Underflow,
    input wire logic                 ch0MatchA,
    input wire logic                 cutoffEvent,
    input wire logic [NUM_PINS-1:0]  pinOut,
    input wire logic [NUM_PINS-1:0]  pinOeN,
    input wire logic                 ch0Run,
    input wire logic                 ch1Run,
    input wire logic                 lockstep,
    input wire logic                 pwmModeActive,
    input wire logic                 transferPulse,
    input wire logic [CMP_WIDTH-1:0] ch0CompareB
);
    logic [NUM_PINS-1:0] paPrev_ff;
    logic [NUM_PINS-1:0] flip;
    always_ff @(posedge mclk) begin
        paPrev_ff <= phaseActive;
    end
    // pins lag one cycle, so compare against last cycle's activity
    assign flip = pinOut ^ paPrev_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_rd_take; hsel && htrans == 2'h2 && hready && !hwrite;
    endsequence
    sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
    property p_read; s_rd_take |=> s_rd_ans; endproperty
    a_read: assert property (p_read) else $error("read wait not one cycle");
    property p_hiz; (pinOeN & pinOut) == 8'h00; endproperty
    a_hiz: assert property (p_hiz) else $error("released pin not low");
    property p_normal; nrst && !cutoffEvent |=> pinOeN == 8'h00; endproperty
    a_normal: assert property (p_normal) else $error("pin released");
    property p_plain;
        $past(nrst) && !$past(cutoffEvent) && !pwmModeActive
            && !$past(pwmModeActive) |-> pinOut == paPrev_ff;
    endproperty
    a_plain: assert property (p_plain) else $error("plain level wrong");
    property p_level;
        $past(nrst) && !$past(cutoffEvent) && pwmModeActive
            && $past(pwmModeActive) |-> flip[2:0] == {3{flip[4]}}
            && flip[5] == flip[4] && flip[7:6] == {2{flip[3]}};
    endproperty
    a_level: assert property (p_level) else $error("phase group split");
    property p_lock;
        lockstep && ($changed(ch0Run) || $changed(ch1Run))
            |-> ch0Run == ch1Run;
    endproperty
    a_lock: assert property (p_lock) else $error("lockstep flags differ");
    property p_pulse;
        transferPulse |-> $past(ch0Run)
            && ($past(ch1Underflow) || $past(ch0MatchA));
    endproperty
    a_pulse: assert property (p_pulse) else $error("transfer no cause");
    property p_single; transferPulse |=> !transferPulse; endproperty
    a_single: assert property (p_single) else $error("pulse too long");
    property p_cmp;
        $changed(ch0CompareB) |-> $past(ch1Underflow) || $past(ch0MatchA)
            || ($past(htrans, 2) == 2'h2 && $past(hwrite, 2));
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare changed alone");
endmodule : pwm_ctrl_checker
bind complementary_pwm_output_control pwm_ctrl_checker #(
    .CMP_WIDTH(CMP_WIDTH)
) u_chk (
    .mclk, .nrst, .htrans, .hwrite, .hsel, .hready, .hreadyout,
    .phaseActive, .ch1Underflow, .ch0MatchA, .cutoffEvent, .pinOut,
    .pinOeN, .ch0Run, .ch1Run, .lockstep, .pwmModeActive,
    .transferPulse, .ch0CompareB
);

// ==== verification/tb_complementary_pwm_output_control.sv ====
// self-checking bench of the pwm output control
// assumes package, design, checker and stage model compiled first
`timescale 1ns/1ns
module tb_complementary_pwm_output_control
    import pwm_ctrl_pkg::*;
;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  phaseActive = 8'h00;
    logic        ch1Underflow = 1'b0;
    logic        ch0MatchA = 1'b0;
    logic        cutoffEvent = 1'b0;
    logic [7:0]  pinOut;
    logic [7:0]  pinOeN;
    logic [7:0]  gate;
    logic        ch0Run;
    logic        ch1Run;
    logic        lockstep;
    logic        transferPulse;
    logic [15:0] ch0CompareB;
    logic [15:0] expB;
    logic [7:0]  mask;
    int          errors = 0;
    int          checked = 0;
    int          xfers = 0;
    int          i;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (transferPulse === 1'b1)
            xfers++;
    end
    // hsel tied high: the bench is the only master
    complementary_pwm_output_control #(.CMP_WIDTH(16)) u_dut (
        .mclk, .nrst, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .phaseActive, .ch1Underflow, .ch0MatchA,
        .cutoffEvent, .pinOut, .pinOeN, .ch0Run, .ch1Run, .lockstep,
        .pwmModeActive(), .transferPulse, .ch0CompareB
    );
    power_stage_model u_stage (.pinOut, .pinOeN, .gate);
    task automatic close_out;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            errors++;
            close_out();
        end
    endtask : wait_rdy
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(nm, r, e);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : rdc
    task automatic pchk(input logic [7:0] o, input logic [7:0] z);
        chk("pinOut", {24'h0, pinOut}, {24'h0, o});
        chk("pinOeN", {24'h0, pinOeN}, {24'h0, z});
    endtask : pchk
    task automatic lvl(input logic [7:0] f, input logic [7:0] e);
        wr(8'h00, {24'h0, f});
        tick(2);
        pchk(e, 8'h00);
    endtask : lvl
    // one-cycle pulse on the chosen source only
    task automatic pulse(input logic u);
        ch1Underflow <= u;
        ch0MatchA <= !u;
        @(posedge mclk);
        ch1Underflow <= 1'b0;
        ch0MatchA <= 1'b0;
        tick(2);
    endtask : pulse
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        tick(1);
        for (i = 0; i < 7; i++) begin
            if (i != 5)
                rdc("reset", 8'(4 * i), (i == 6) ? 32'hFFFF : 32'h0);
        end
        wr(8'h20, 32'hFF);
        rdc("unmapped", 8'h20, 32'h0);
        wr(8'h00, 32'hFF);
        rdc("funcCtrl", 8'h00, {24'h0, FUNC_CTRL_WMASK});
        $display("test registers done");
        phaseActive <= 8'h5A;
        for (i = 0; i < 12; i++) begin
            mask = ({8{i >= 6}} & COUNTER_PHASE_PINS)
                 | ({8{(i / 3) % 2 == 1}} & ~COUNTER_PHASE_PINS);
            lvl({4'h0, 2'(i / 3), 2'(i % 3 + 1)}, 8'h5A ^ ~mask);
        end
        lvl(8'h00, 8'h5A);
        lvl(8'h81, 8'h5A);
        $display("test levels done");
        phaseActive <= 8'hFF;
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1B);
        wr(8'h08, 32'hE4);
        rdc("cutCh0", 8'h04, 32'h1B);
        rdc("cutCh1", 8'h08, 32'hE4);
        cutoffEvent <= 1'b1;
        tick(2);
        pchk(8'h99, 8'h42);
        chk("gate", {24'h0, gate}, 32'h99);
        rdc("status", 8'h14, 32'h2650A);
        cutoffEvent <= 1'b0;
        tick(2);
        pchk(8'hFF, 8'h00);
        wr(8'h08, 32'h0);
        $display("test cutoff done");
        wr(8'h10, 32'h1);
        tick(1);
        chk("run", {30'h0, ch1Run, ch0Run}, 32'h1);
        wr(8'h04, 32'hFF);
        rdc("cutLocked", 8'h04, 32'h1B);
        wr(8'h0C, 32'h1);
        wr(8'h10, 32'h1);
        tick(1);
        chk("lock", {29'h0, lockstep, ch1Run, ch0Run}, 32'h7);
        wr(8'h10, 32'h0);
        tick(1);
        chk("stop", {30'h0, ch1Run, ch0Run}, 32'h0);
        $display("test run done");
        wr(8'h0C, 32'h20);
        wr(8'h18, 32'h1234);
        rdc("cmpB", 8'h18, 32'h1234);
        expB = 16'h1234;
        wr(8'h10, 32'h1);
        for (i = 2; i < 4; i++) begin
            wr(8'h00, 32'(i));
            wr(8'h1C, 32'h0A00 + 32'(i));
            pulse(i == 3);
            chk("cmpWrong", {16'h0, ch0CompareB}, {16'h0, expB});
            pulse(i == 2);
            expB = 16'h0A00 + 16'(i);
            chk("cmpXfer", {16'h0, ch0CompareB}, {16'h0, expB});
        end
        wr(8'h10, 32'h0);
        wr(8'h1C, 32'h0777);
        pulse(1'b0);
        chk("cmpStop", {16'h0, ch0CompareB}, {16'h0, expB});
        chk("xfers", 32'(xfers), 32'h2);
        $display("test transfer done");
        close_out();
    end
endmodule : tb_complementary_pwm_output_control
